// ---- rtl/rstsq_pkg.sv ----
// package of constants and types for the reset sequencer
package rstsq_pkg;
  localparam int unsigned REF_CLK_HZ = 40_000_000;
  localparam int unsigned REF_CLK_NS = 25;
  localparam int unsigned RC_OSC_HZ = 32_768;
  // start-up times
  localparam int unsigned T_POR_MS = 72;
  localparam int unsigned T_WAKE_FIXED_MS = 18;
  localparam int unsigned T_WAKE_025_US = 250;
  localparam int unsigned T_WAKE_18_MS = 18;
  localparam int unsigned T_WAKE_60_MS = 60;
  localparam int unsigned T_WAKE_1S_S = 1;
  localparam int unsigned T_WAKE_FAST_US = 60;
  localparam int unsigned CNT_W = 20;
  // least time in rc ticks, rounded up, never below one
  function automatic logic [CNT_W-1:0] rc_ticks(input longint unsigned t_us);
    longint unsigned n;
    n = (t_us * RC_OSC_HZ + 64'd999_999) / 64'd1_000_000;
    if (n == 0) n = 1;
    return n[CNT_W-1:0];
  endfunction : rc_ticks
  localparam logic [CNT_W-1:0] POR_TICKS = rc_ticks(T_POR_MS * 1000);
  localparam logic [CNT_W-1:0] WAKE_FIXED_TICKS = rc_ticks(T_WAKE_FIXED_MS * 1000);
  localparam logic [CNT_W-1:0] WAKE_025_TICKS = rc_ticks(T_WAKE_025_US);
  localparam logic [CNT_W-1:0] WAKE_18_TICKS = rc_ticks(T_WAKE_18_MS * 1000);
  localparam logic [CNT_W-1:0] WAKE_60_TICKS = rc_ticks(T_WAKE_60_MS * 1000);
  localparam logic [CNT_W-1:0] WAKE_1S_TICKS = rc_ticks(T_WAKE_1S_S * 1_000_000);
  // fast wake counts core clock cycles, clock keeps running
  localparam logic [CNT_W-1:0] WAKE_FAST_CYC =
    CNT_W'((T_WAKE_FAST_US * 1000 + REF_CLK_NS - 1) / REF_CLK_NS);
  // register byte offsets
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_WAKE = 4'h8;
  // field encodings
  localparam logic [1:0] WDS_025 = 2'b10;
  localparam logic [1:0] WDS_18 = 2'b11;
  localparam logic [1:0] WDS_60 = 2'b00;
  localparam logic [1:0] WDS_1S = 2'b01;
  localparam logic [1:0] BOR_DISABLED = 2'b11;
  // timeout/powerdown flag values {timeout_flag, powerdown_flag}
  localparam logic [1:0] TOPD_POR = 2'b11;
  localparam logic [1:0] TOPD_WDT_PD = 2'b00;
  localparam logic [1:0] TOPD_WDT_ACT = 2'b01;
  localparam logic [1:0] TOPD_MASTER_CLEAR_N_PD = 2'b10;
  localparam int unsigned PC_W = 11;
  localparam logic [PC_W-1:0] RESET_ADDR = '1;
  localparam int unsigned WAKE_W = 8;
  typedef struct packed {
    logic programmable;
    logic [1:0] brownout_level_sel;
    logic sleep_clock_off;
    logic [1:0] wake_delay_sel;
  } rstsq_fuse_t;
  localparam rstsq_fuse_t FUSE_RESET = 6'h3f;
  typedef enum logic [2:0] {CAUSE_POR, CAUSE_MASTER_CLEAR_N, CAUSE_WDT, CAUSE_WAKE, CAUSE_BOR}
    rstsq_cause_t;
  typedef enum logic [1:0] {ST_HOLD, ST_COUNT, ST_RUN} rstsq_state_t;
  typedef struct packed {
    logic in_reset;
    rstsq_cause_t cause;
    logic timeout_flag;
    logic powerdown_flag;
  } rstsq_status_t;
endpackage : rstsq_pkg

// ---- rtl/rstsq_top.sv ----
// reset sequencer with avalon-mm register slave
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module rstsq_top #(
  parameter logic [19:0] POR_TICKS = rstsq_pkg::POR_TICKS,
  parameter logic [19:0] WAKE_FIXED_TICKS = rstsq_pkg::WAKE_FIXED_TICKS,
  parameter logic [19:0] WAKE_025_TICKS = rstsq_pkg::WAKE_025_TICKS,
  parameter logic [19:0] WAKE_18_TICKS = rstsq_pkg::WAKE_18_TICKS,
  parameter logic [19:0] WAKE_60_TICKS = rstsq_pkg::WAKE_60_TICKS,
  parameter logic [19:0] WAKE_1S_TICKS = rstsq_pkg::WAKE_1S_TICKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins and analog
  input wire logic master_clear_n,
  input wire logic rc_osc_pulse,
  input wire logic rc_osc_running,
  input wire logic brownout_below,
  // core side
  input wire logic watchdog_overflow,
  input wire logic powerdown_active,
  input wire logic wake_event,
  input wire logic [7:0] wake_pins,
  // outputs
  output logic core_reset_n,
  output logic restart_load,
  output logic [10:0] restart_addr,
  output logic [1:0] brownout_level_sel,
  output logic sleep_clock_off
);
  // synchronisers for asynchronous pins
  logic [2:0] rc_s_q;
  logic [1:0] master_clear_n_s_q;
  logic [1:0] rco_s_q;
  logic [1:0] bor_s_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rc_s_q <= 3'h0;
      master_clear_n_s_q <= 2'h0;
      rco_s_q <= 2'h0;
      bor_s_q <= 2'h0;
    end else begin
      rc_s_q <= {rc_s_q[1:0], rc_osc_pulse};
      master_clear_n_s_q <= {master_clear_n_s_q[0], master_clear_n};
      rco_s_q <= {rco_s_q[0], rc_osc_running};
      bor_s_q <= {bor_s_q[0], brownout_below};
    end
  end

  logic rc_tick;
  logic master_clear_n_high;
  logic osc_ok;
  logic bor_hold;
  rstsq_pkg::rstsq_fuse_t fuse_q;
  assign rc_tick = rc_s_q[1] & ~rc_s_q[2];
  assign master_clear_n_high = master_clear_n_s_q[1];
  assign osc_ok = rco_s_q[1];
  assign bor_hold = bor_s_q[1] & (fuse_q.brownout_level_sel != rstsq_pkg::BOR_DISABLED);

  // sequencer state
  rstsq_pkg::rstsq_state_t st_q, st_d;
  rstsq_pkg::rstsq_cause_t cause_q, cause_d;
  logic [19:0] cnt_q, cnt_d;
  logic fast_q, fast_d;
  logic [1:0] topd_q, topd_d;
  logic [7:0] wake_q, wake_d;
  logic rst_n_q, rst_n_d;
  logic restart_q, restart_d;
  logic [19:0] limit;
  logic tick;
  logic wake_clr;
  logic [7:0] wake_clr_mask;

  always_comb begin
    limit = POR_TICKS;
    if (cause_q == rstsq_pkg::CAUSE_WAKE) begin
      if (!fuse_q.programmable) begin
        limit = WAKE_FIXED_TICKS;
      end else if (fast_q) begin
        limit = rstsq_pkg::WAKE_FAST_CYC;
      end else begin
        case (fuse_q.wake_delay_sel)
          rstsq_pkg::WDS_025: limit = WAKE_025_TICKS;
          rstsq_pkg::WDS_18: limit = WAKE_18_TICKS;
          rstsq_pkg::WDS_60: limit = WAKE_60_TICKS;
          rstsq_pkg::WDS_1S: limit = WAKE_1S_TICKS;
          default: limit = WAKE_18_TICKS;
        endcase
      end
    end
  end

  assign tick = fast_q ? 1'b1 : rc_tick;

  always_comb begin
    st_d = st_q;
    cause_d = cause_q;
    cnt_d = cnt_q;
    fast_d = fast_q;
    topd_d = topd_q;
    restart_d = 1'b0;
    wake_d = wake_q & ~(wake_clr ? wake_clr_mask : 8'h00);
    if (!master_clear_n_high) begin
      st_d = rstsq_pkg::ST_HOLD;
      if (st_q == rstsq_pkg::ST_RUN && powerdown_active) begin
        topd_d = rstsq_pkg::TOPD_MASTER_CLEAR_N_PD;
      end
      // clear held low during power-up keeps the power-on delay
      if (cause_q != rstsq_pkg::CAUSE_POR) begin
        cause_d = rstsq_pkg::CAUSE_MASTER_CLEAR_N;
      end
    end else if (bor_hold) begin
      st_d = rstsq_pkg::ST_HOLD;
      if (cause_q != rstsq_pkg::CAUSE_POR) begin
        cause_d = rstsq_pkg::CAUSE_BOR;
      end
    end else if (st_q == rstsq_pkg::ST_RUN && watchdog_overflow) begin
      st_d = rstsq_pkg::ST_HOLD;
      cause_d = rstsq_pkg::CAUSE_WDT;
      topd_d = powerdown_active ? rstsq_pkg::TOPD_WDT_PD : rstsq_pkg::TOPD_WDT_ACT;
    end else if (st_q == rstsq_pkg::ST_RUN && powerdown_active && wake_event) begin
      st_d = rstsq_pkg::ST_HOLD;
      cause_d = rstsq_pkg::CAUSE_WAKE;
      fast_d = fuse_q.programmable & ~fuse_q.sleep_clock_off &
               (fuse_q.wake_delay_sel == rstsq_pkg::WDS_025);
      wake_d = wake_q | wake_pins;
    end else begin
      case (st_q)
        rstsq_pkg::ST_HOLD: begin
          cnt_d = 20'h0_0000;
          if (cause_q == rstsq_pkg::CAUSE_POR) begin
            if (osc_ok) begin
              st_d = rstsq_pkg::ST_COUNT;
            end
          end else if (cause_q == rstsq_pkg::CAUSE_WAKE) begin
            st_d = rstsq_pkg::ST_COUNT;
          end else begin
            st_d = rstsq_pkg::ST_RUN;
            restart_d = 1'b1;
          end
        end
        rstsq_pkg::ST_COUNT: begin
          if (tick) begin
            if (cnt_q + 20'h0_0001 >= limit) begin
              st_d = rstsq_pkg::ST_RUN;
              restart_d = 1'b1;
              fast_d = 1'b0;
            end else begin
              cnt_d = cnt_q + 20'h0_0001;
            end
          end
        end
        rstsq_pkg::ST_RUN: begin
          cnt_d = 20'h0_0000;
        end
        default: begin
          st_d = rstsq_pkg::ST_HOLD;
        end
      endcase
    end
    // pin set wins over a software clear in the same cycle
    if (st_q == rstsq_pkg::ST_RUN && powerdown_active && wake_event && master_clear_n_high &&
        !bor_hold && !watchdog_overflow) begin
      wake_d = (wake_q & ~(wake_clr ? wake_clr_mask : 8'h00)) | wake_pins;
    end
    rst_n_d = (st_d == rstsq_pkg::ST_RUN);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= rstsq_pkg::ST_HOLD;
      cause_q <= rstsq_pkg::CAUSE_POR;
      cnt_q <= 20'h0_0000;
      fast_q <= 1'b0;
      topd_q <= rstsq_pkg::TOPD_POR;
      wake_q <= 8'h00;
      rst_n_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cause_q <= cause_d;
      cnt_q <= cnt_d;
      fast_q <= fast_d;
      topd_q <= topd_d;
      wake_q <= wake_d;
      rst_n_q <= rst_n_d;
      restart_q <= restart_d;
    end
  end

  // avalon slave: one cycle of waitrequest, then low for one cycle
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  rstsq_pkg::rstsq_fuse_t fuse_d;
  rstsq_pkg::rstsq_status_t stat;
  logic wr_take;

  assign stat = '{in_reset: ~rst_n_q, cause: cause_q, timeout_flag: topd_q[1],
                  powerdown_flag: topd_q[0]};
  assign wr_take = avs_write & ~wait_q;
  assign wake_clr = wr_take & avs_byteenable[0] & (avs_address == rstsq_pkg::OFS_WAKE);
  assign wake_clr_mask = avs_writedata[7:0];

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    fuse_d = fuse_q;
    if ((avs_read | avs_write) & wait_q) begin
      wait_d = 1'b0;
      case (avs_address)
        rstsq_pkg::OFS_CFG: rdata_d = {26'h000_0000, fuse_q};
        rstsq_pkg::OFS_STATUS: rdata_d = {26'h000_0000, stat};
        rstsq_pkg::OFS_WAKE: rdata_d = {24'h00_0000, wake_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_take & avs_byteenable[0] & (avs_address == rstsq_pkg::OFS_CFG)) begin
      fuse_d = avs_writedata[5:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      fuse_q <= rstsq_pkg::FUSE_RESET;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      fuse_q <= fuse_d;
    end
  end

  // output registers
  logic [10:0] raddr_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      raddr_q <= rstsq_pkg::RESET_ADDR;
    end else begin
      raddr_q <= rstsq_pkg::RESET_ADDR;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign core_reset_n = rst_n_q;
  assign restart_load = restart_q;
  assign restart_addr = raddr_q;
  assign brownout_level_sel = fuse_q.brownout_level_sel;
  assign sleep_clock_off = fuse_q.sleep_clock_off;
endmodule : rstsq_top

// ---- tb/rstsq_properties.sv ----
// checker for the reset sequencer ports
`timescale 1ns/100ps
module rstsq_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // reset sources
  input wire logic master_clear_n,
  input wire logic brownout_below,
  input wire logic watchdog_overflow,
  input wire logic powerdown_active,
  input wire logic wake_event,
  // outputs
  input wire logic core_reset_n,
  input wire logic restart_load,
  input wire logic [10:0] restart_addr,
  input wire logic [1:0] brownout_level_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_clear_low;
    (!master_clear_n)[*3];
  endsequence
  sequence s_quiet;
    (master_clear_n && !watchdog_overflow && !wake_event)[*3];
  endsequence
  a_clear_holds: assert property (s_clear_low |=> !core_reset_n)
    else $error("core runs with clear low");
  a_load_on_rise: assert property (restart_load |-> $rose(core_reset_n) ##1 !restart_load)
    else $error("restart pulse not on release");
  a_restart_top: assert property (restart_addr == 11'h7ff)
    else $error("restart address wrong");
  a_bor_holds: assert property ((brownout_below && brownout_level_sel != 2'b11)[*4]
    |-> !core_reset_n)
    else $error("core runs in brownout");
  a_bor_off: assert property (s_quiet ##0 (core_reset_n && brownout_level_sel == 2'b11)
    |=> core_reset_n)
    else $error("disabled brownout reset");
  a_wdt_resets: assert property (watchdog_overflow && core_reset_n |-> ##[1:3] !core_reset_n)
    else $error("no watchdog reset");
  a_wake_resets: assert property (wake_event && powerdown_active && core_reset_n
    |-> ##[1:3] !core_reset_n)
    else $error("no wake reset");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
endmodule : rstsq_checker
bind rstsq_top rstsq_checker u_chk (.ref_clk, .arst_n, .avs_read, .avs_write, .avs_waitrequest,
  .master_clear_n, .brownout_below, .watchdog_overflow, .powerdown_active, .wake_event,
  .core_reset_n, .restart_load, .restart_addr, .brownout_level_sel);

// ---- tb/rstsq_board_model.sv ----
// board model: clear pin circuit and rc oscillator
`timescale 1ns/100ps
module rstsq_board_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bench request
  input wire logic clear_req,
  // to device
  output logic master_clear_n,
  output logic rc_osc_pulse,
  output logic rc_osc_running
);
  logic [4:0] hold_q;
  logic [3:0] div_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 5'h14;
      div_q <= 4'h0;
    end else begin
      if (hold_q != 5'h00) hold_q <= hold_q - 5'h01;
      div_q <= div_q + 4'h1;
    end
  end
  // pin held low through power-up, then on request
  assign master_clear_n = (hold_q == 5'h00) && !clear_req;
  assign rc_osc_running = arst_n;
  assign rc_osc_pulse = div_q[3];
endmodule : rstsq_board_model

// ---- tb/reset_sequencer_test.sv ----
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module reset_sequencer_test;
  logic ref_clk, arst_n, rd, wr, waitreq, clr, master_clear_n_n, rc_p, rc_run, bor, wdt, pd, wake, core_n;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [7:0] pins;
  logic [3:0] be;
  logic sco;
  int mismatches, n_compared, cycles, n, m;
  logic [31:0] cfg_tab [6] = '{32'h0000_003e, 32'h0000_003f, 32'h0000_003c, 32'h0000_003d,
    32'h0000_001f, 32'h0000_003a};
  int tk_tab [6] = '{4, 5, 7, 8, 6, 0};
  // short start-up delays in rc ticks, fixed wake apart from the 18 ms choice
  localparam logic [19:0] TK_POR = 20'h0_0006;
  localparam logic [19:0] TK_FIXED = 20'h0_0006;
  localparam logic [19:0] TK_025 = 20'h0_0004;
  localparam logic [19:0] TK_18 = 20'h0_0005;
  localparam logic [19:0] TK_60 = 20'h0_0007;
  localparam logic [19:0] TK_1S = 20'h0_0008;
  rstsq_top #(.POR_TICKS(TK_POR), .WAKE_FIXED_TICKS(TK_FIXED), .WAKE_025_TICKS(TK_025),
    .WAKE_18_TICKS(TK_18), .WAKE_60_TICKS(TK_60), .WAKE_1S_TICKS(TK_1S)) dut (
    .ref_clk, .arst_n, .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .master_clear_n(master_clear_n_n), .rc_osc_pulse(rc_p), .rc_osc_running(rc_run), .brownout_below(bor),
    .watchdog_overflow(wdt), .powerdown_active(pd), .wake_event(wake), .wake_pins(pins),
    .core_reset_n(core_n), .restart_load(), .restart_addr(), .brownout_level_sel(),
    .sleep_clock_off(sco));
  rstsq_board_model u_board (.ref_clk, .arst_n, .clear_req(clr), .master_clear_n(master_clear_n_n),
    .rc_osc_pulse(rc_p), .rc_osc_running(rc_run));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task cmp_rng(input string what, input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, v);
    end
  endtask : cmp_rng
  // request stands until waitrequest is seen low at a rising edge
  task wait_ans;
    @(posedge ref_clk);
    while (waitreq !== 1'b0) begin
      @(posedge ref_clk);
    end
    d = rdata;
  endtask : wait_ans
  task bus_wr(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    wait_ans();
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask : bus_wr
  task bus_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    addr <= a;
    rd <= 1'b1;
    wait_ans();
    rd <= 1'b0;
    cmp(what, exp, d);
    @(posedge ref_clk);
  endtask : bus_rd
  task wait_core(input logic lvl, output int cnt);
    cnt = 0;
    @(negedge ref_clk);
    while (core_n !== lvl) begin
      cnt++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
  endtask : wait_core
  task t_por;
    wait_core(1'b1, n);
    cmp_rng("por delay", n, 100, 132);
    bus_rd(rstsq_pkg::OFS_STATUS, 32'h0000_0003, "status por");
    bus_rd(rstsq_pkg::OFS_CFG, 32'h0000_003f, "cfg reset");
    bus_rd(4'hc, 32'h0000_0000, "unmapped");
    bus_wr(rstsq_pkg::OFS_STATUS, 32'h0000_00ff);
    bus_rd(rstsq_pkg::OFS_STATUS, 32'h0000_0003, "status read only");
    be <= 4'he;
    bus_wr(rstsq_pkg::OFS_CFG, 32'h0000_0000);
    be <= 4'hf;
    bus_rd(rstsq_pkg::OFS_CFG, 32'h0000_003f, "cfg byte enable off");
    $display("power-on test done");
  endtask : t_por
  task t_wdt(input logic p, input logic [31:0] st);
    pd <= p;
    wdt <= 1'b1;
    @(posedge ref_clk);
    wdt <= 1'b0;
    wait_core(1'b0, n);
    wait_core(1'b1, n);
    pd <= 1'b0;
    bus_rd(rstsq_pkg::OFS_STATUS, st, "status watchdog");
    $display("watchdog test done");
  endtask : t_wdt
  task t_clear(input logic p, input logic [31:0] st);
    pd <= p;
    clr <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp("core held", 32'h0000_0000, {31'h0, core_n});
    clr <= 1'b0;
    pd <= 1'b0;
    wait_core(1'b1, n);
    bus_rd(rstsq_pkg::OFS_STATUS, st, "status clear");
    $display("clear test done");
  endtask : t_clear
  task t_wake;
    int lo, hi;
    for (int i = 0; i < 6; i++) begin
      lo = tk_tab[i] ? (tk_tab[i] - 1) * 16 : 2400;
      hi = tk_tab[i] ? tk_tab[i] * 16 + 16 : 2416;
      bus_wr(rstsq_pkg::OFS_CFG, cfg_tab[i]);
      cmp("sleep clock off", {31'h0, cfg_tab[i][2]}, {31'h0, sco});
      pd <= 1'b1;
      pins <= 8'h01 << i;
      wake <= 1'b1;
      @(posedge ref_clk);
      wake <= 1'b0;
      pd <= 1'b0;
      wait_core(1'b0, n);
      wait_core(1'b1, m);
      cmp_rng("wake delay", n + m, lo, hi);
    end
    bus_rd(rstsq_pkg::OFS_WAKE, 32'h0000_003f, "wake flags");
    bus_wr(rstsq_pkg::OFS_WAKE, 32'h0000_0005);
    bus_rd(rstsq_pkg::OFS_WAKE, 32'h0000_003a, "wake clear");
    $display("wake test done");
  endtask : t_wake
  task t_bor;
    bor <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp("bor disabled", 32'h0000_0001, {31'h0, core_n});
    bus_wr(rstsq_pkg::OFS_CFG, 32'h0000_0027);
    repeat (10) @(posedge ref_clk);
    cmp("bor held", 32'h0000_0000, {31'h0, core_n});
    bor <= 1'b0;
    wait_core(1'b1, n);
    cmp_rng("bor release", n, 0, 8);
    $display("brownout test done");
  endtask : t_bor
  initial begin
    {arst_n, rd, wr, clr, bor, wdt, pd, wake} = '0;
    {addr, wdata, pins} = '0;
    be = 4'hf;
    {mismatches, n_compared, cycles} = '0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_por();
    t_wdt(1'b1, 32'h0000_0008);
    t_wdt(1'b0, 32'h0000_0009);
    t_clear(1'b0, 32'h0000_0005);
    t_clear(1'b1, 32'h0000_0006);
    t_wake();
    t_bor();
    give_verdict();
  end
endmodule : reset_sequencer_test
